// ==== src/gism_params.svh ====
// register map and field constants for the interrupt status and mask block
// assumes an i2c slave outside presents byte-wide register reads and writes
`ifndef GISM_PARAMS_SVH
`define GISM_PARAMS_SVH
`define GISM_ADDR_ICR_MSB     8'h10
`define GISM_ADDR_ICR_LSB     8'h11
`define GISM_ADDR_SEN_MSB     8'h12
`define GISM_ADDR_SEN_LSB     8'h13
`define GISM_ADDR_SST_MSB     8'h14
`define GISM_ADDR_SST_LSB     8'h15
`define GISM_ADDR_PEN_HIGH    8'h16
`define GISM_ADDR_PEN_MID     8'h17
`define GISM_ADDR_PEN_LOW     8'h18
`define GISM_ADDR_PST_HIGH    8'h19
`define GISM_ADDR_PST_MID     8'h1A
`define GISM_ADDR_PST_LOW     8'h1B
`define GISM_SRC_WIDTH        9
`define GISM_PIN_WIDTH        24
`define GISM_GPIO_SUMMARY_BIT 8
`define GISM_ICR_GLOBAL_BIT   0
`define GISM_ICR_TYPE_BIT     1
`define GISM_ICR_POL_BIT      2
`define GISM_RESET_BYTE       8'h00
`define GISM_RESET_SRC        9'h000
`define GISM_RESET_PIN        24'h000000
`define GISM_RESET_ICR        3'h0
`define GISM_PULSE_NS         250
`define GISM_CLK_NS           20
`define GISM_PULSE_CYCLES     ((`GISM_PULSE_NS + `GISM_CLK_NS - 1) / `GISM_CLK_NS)
`endif

// ==== src/gism_pkg.sv ====
// types shared by the interrupt status and mask block
// assumes gism_params.svh for widths
`include "gism_params.svh"
package gism_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } gism_reg_req_type;

    typedef struct packed {
        logic                        wakeup;
        logic [1:0]                  keypad;
        logic                        rotator;
        logic                        rotator_overflow;
        logic [2:0]                  pwm;
        logic [`GISM_PIN_WIDTH-1:0]  gpio_pin;
    } gism_events_type;
endpackage

// ==== src/gism_w1c_bank.sv ====
// sticky event bits cleared by writing one, set having priority over clear
// assumes events and clear strobes are on sys_clk
`timescale 1ns/1ns
`include "gism_params.svh"
module gism_w1c_bank #(
    parameter int WIDTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] set_bits,
    input  wire logic [WIDTH-1:0] clear_bits,
    output logic      [WIDTH-1:0] status_q
);
    // an event in the clearing cycle survives the clear
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~clear_bits) | set_bits;
        end
    end
endmodule // gism_w1c_bank

// ==== src/gism_irq_ctrl.sv ====
// What this block does
// - source bits: wakeup, keypad, rotator, pwm, gpio
// - write one clears source bit
// - 24 per-pin interrupt enable bits
// - enable one forwards pin, zero blocks
// - pin enables split high, mid, low bytes
// - 24 per-pin status bits record events
// - pin status sets regardless of enable
// - pin status uses same byte split
// - source status sets regardless of enable
// - write one clears pin status bit
// - global enable gates host interrupt
//
// register file of the port expander interrupt controller, byte wide
// assumes an outside i2c slave issues one-cycle rd/wr strobes with address
`timescale 1ns/1ns
`include "gism_params.svh"
module gism_irq_ctrl (
    input  wire logic                       sys_clk,
    input  wire logic                       reset,
    input  wire gism_pkg::gism_reg_req_type reg_req,
    input  wire gism_pkg::gism_events_type  events,
    output logic [7:0]                      rdata_q,
    output logic                            rvalid_q,
    output logic                            irq_q,
    output logic                            irq_oe_q
);
    logic [`GISM_SRC_WIDTH-1:0] src_enable_q;
    logic [`GISM_PIN_WIDTH-1:0] pin_enable_q;
    logic [2:0]                 icr_q;
    logic [`GISM_SRC_WIDTH-1:0] src_status;
    logic [`GISM_PIN_WIDTH-1:0] pin_status;
    logic [`GISM_SRC_WIDTH-1:0] src_set;
    logic [`GISM_SRC_WIDTH-1:0] src_clear;
    logic [`GISM_PIN_WIDTH-1:0] pin_clear;
    logic                       request;
    logic                       request_q;
    logic [3:0]                 pulse_cnt_q;
    logic [7:0]                 rdata_d;
    logic                       wr;

    assign wr = reg_req.wr;

    // summary bit sets while any enabled pin is pending and holds until cleared by writing one
    always_comb begin
        src_set = {|(pin_status & pin_enable_q), events.pwm,
                   events.rotator_overflow, events.rotator,
                   events.keypad, events.wakeup};
    end

    always_comb begin
        src_clear = '0;
        pin_clear = '0;
        if (wr && reg_req.addr == `GISM_ADDR_SST_MSB)
            src_clear[`GISM_GPIO_SUMMARY_BIT] = reg_req.wdata[0];
        if (wr && reg_req.addr == `GISM_ADDR_SST_LSB)
            src_clear[7:0] = reg_req.wdata;
        if (wr && reg_req.addr == `GISM_ADDR_PST_HIGH)
            pin_clear[23:16] = reg_req.wdata;
        if (wr && reg_req.addr == `GISM_ADDR_PST_MID)
            pin_clear[15:8] = reg_req.wdata;
        if (wr && reg_req.addr == `GISM_ADDR_PST_LOW)
            pin_clear[7:0] = reg_req.wdata;
    end

    gism_w1c_bank #(.WIDTH(`GISM_SRC_WIDTH)) u_src_bank (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .set_bits   (src_set),
        .clear_bits (src_clear),
        .status_q   (src_status)
    );

    gism_w1c_bank #(.WIDTH(`GISM_PIN_WIDTH)) u_pin_bank (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .set_bits   (events.gpio_pin),
        .clear_bits (pin_clear),
        .status_q   (pin_status)
    );

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            icr_q <= `GISM_RESET_ICR;
        end else if (wr && reg_req.addr == `GISM_ADDR_ICR_LSB) begin
            icr_q <= reg_req.wdata[2:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            src_enable_q <= `GISM_RESET_SRC;
        end else if (wr && reg_req.addr == `GISM_ADDR_SEN_MSB) begin
            src_enable_q[`GISM_GPIO_SUMMARY_BIT] <= reg_req.wdata[0];
        end else if (wr && reg_req.addr == `GISM_ADDR_SEN_LSB) begin
            src_enable_q[7:0] <= reg_req.wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pin_enable_q <= `GISM_RESET_PIN;
        end else if (wr) begin
            if (reg_req.addr == `GISM_ADDR_PEN_HIGH)
                pin_enable_q[23:16] <= reg_req.wdata;
            if (reg_req.addr == `GISM_ADDR_PEN_MID)
                pin_enable_q[15:8] <= reg_req.wdata;
            if (reg_req.addr == `GISM_ADDR_PEN_LOW)
                pin_enable_q[7:0] <= reg_req.wdata;
        end
    end

    // unmapped addresses and reserved bits read as zero
    always_comb begin
        rdata_d = `GISM_RESET_BYTE;
        unique case (reg_req.addr)
            `GISM_ADDR_ICR_LSB:  rdata_d = {5'h00, icr_q};
            `GISM_ADDR_SEN_MSB:  rdata_d = {7'h00, src_enable_q[8]};
            `GISM_ADDR_SEN_LSB:  rdata_d = src_enable_q[7:0];
            `GISM_ADDR_SST_MSB:  rdata_d = {7'h00, src_status[8]};
            `GISM_ADDR_SST_LSB:  rdata_d = src_status[7:0];
            `GISM_ADDR_PEN_HIGH: rdata_d = pin_enable_q[23:16];
            `GISM_ADDR_PEN_MID:  rdata_d = pin_enable_q[15:8];
            `GISM_ADDR_PEN_LOW:  rdata_d = pin_enable_q[7:0];
            `GISM_ADDR_PST_HIGH: rdata_d = pin_status[23:16];
            `GISM_ADDR_PST_MID:  rdata_d = pin_status[15:8];
            `GISM_ADDR_PST_LOW:  rdata_d = pin_status[7:0];
            default:             rdata_d = `GISM_RESET_BYTE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdata_q  <= `GISM_RESET_BYTE;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= reg_req.rd ? rdata_d : rdata_q;
            rvalid_q <= reg_req.rd;
        end
    end

    assign request = icr_q[`GISM_ICR_GLOBAL_BIT] & |(src_status & src_enable_q);

    // edge mode gives a fixed pulse on each rising request; level mode follows it
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            request_q   <= 1'b0;
            pulse_cnt_q <= 4'h0;
        end else begin
            request_q <= request;
            if (request && !request_q)
                // the rising cycle itself is the first cycle of the pulse
                pulse_cnt_q <= 4'(`GISM_PULSE_CYCLES - 1);
            else if (pulse_cnt_q != 4'h0)
                pulse_cnt_q <= pulse_cnt_q - 4'h1;
        end
    end

    // irq_q is the active-high request in level polarity terms; irq_oe_q drives the open-drain pin
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_q    <= 1'b0;
            irq_oe_q <= 1'b0;
        end else begin
            irq_q <= icr_q[`GISM_ICR_TYPE_BIT] ? (pulse_cnt_q != 4'h0 || (request && !request_q))
                                               : request;
            irq_oe_q <= icr_q[`GISM_ICR_TYPE_BIT]
                        ? ((pulse_cnt_q != 4'h0 || (request && !request_q))
                           ^ icr_q[`GISM_ICR_POL_BIT])
                        : (request ^ icr_q[`GISM_ICR_POL_BIT]);
        end
    end
endmodule // gism_irq_ctrl

// ==== verification/gism_irq_ctrl_sva.sv ====
// port assertions for the interrupt status and mask block
// assumes one-cycle strobes and a read answer one cycle after rd
`timescale 1ns/1ns
`include "gism_params.svh"
module gism_irq_ctrl_chk (
    input wire logic                       sys_clk,
    input wire logic                       reset,
    input wire gism_pkg::gism_reg_req_type reg_req,
    input wire gism_pkg::gism_events_type  events,
    input wire logic [7:0]                 rdata_q,
    input wire logic                       rvalid_q,
    input wire logic                       irq_q,
    input wire logic                       irq_oe_q
);
    logic glob_q;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // shadow of the global enable, updated on the same edge as the design
    always_ff @(posedge sys_clk) begin
        if (reset) glob_q <= 1'b0;
        else if (reg_req.wr && reg_req.addr == `GISM_ADDR_ICR_LSB) glob_q <= reg_req.wdata[0];
    end
    sequence rd_at(logic [7:0] a);
        reg_req.rd && reg_req.addr == a;
    endsequence
    sequence clr_at(logic [7:0] a);
        reg_req.wr && reg_req.addr == a && reg_req.wdata[0];
    endsequence
    a_read_answer: assert property (reg_req.rd |=> rvalid_q) else $error("read not answered");
    a_answer_cause: assert property (rvalid_q |-> $past(reg_req.rd)) else $error("stray rvalid");
    a_rdata_hold: assert property (!reg_req.rd |=> $stable(rdata_q)) else $error("rdata moved");
    a_unmapped_zero: assert property (rd_at(8'h00) |=> rdata_q == 8'h00) else $error("unmapped");
    a_src_sets: assert property (events.wakeup ##1 !reg_req.wr ##1 rd_at(8'h15)
        |=> rdata_q[0]) else $error("source bit not set");
    a_pin_sets: assert property (events.gpio_pin[23] ##1 !reg_req.wr
        ##1 rd_at(`GISM_ADDR_PST_HIGH) |=> rdata_q[7]) else $error("pin bit not set");
    a_src_clear: assert property (clr_at(8'h15) ##0 !events.wakeup ##1 !events.wakeup
        ##1 rd_at(8'h15) |=> !rdata_q[0]) else $error("source bit not cleared");
    a_pin_clear: assert property (clr_at(`GISM_ADDR_PST_LOW) ##0 !events.gpio_pin[0]
        ##1 !events.gpio_pin[0] ##1 rd_at(`GISM_ADDR_PST_LOW) |=> !rdata_q[0])
        else $error("pin bit not cleared");
    a_global_gate: assert property (!glob_q |=> !irq_q) else $error("irq while disabled");
endmodule // gism_irq_ctrl_chk
bind gism_irq_ctrl gism_irq_ctrl_chk gism_irq_ctrl_chk_i (.sys_clk(sys_clk), .reset(reset),
    .reg_req(reg_req), .events(events), .rdata_q(rdata_q), .rvalid_q(rvalid_q),
    .irq_q(irq_q), .irq_oe_q(irq_oe_q));

// ==== verification/gism_host_model.sv ====
// host side register master issuing one-cycle strobes at the falling edge
// assumes the block answers a read in the following cycle
`timescale 1ns/1ns
module gism_host_model (
    input  wire logic                  sys_clk,
    output gism_pkg::gism_reg_req_type reg_req,
    input  wire logic [7:0]            rdata_q,
    input  wire logic                  rvalid_q
);
    initial reg_req = '0;
    // idle address and data show the inverse so nothing stale looks valid
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk) reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge sys_clk) reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge sys_clk) reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'hA5};
        @(negedge sys_clk) reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'h5A};
        d = rdata_q;
        v = rvalid_q;
    endtask
    task automatic clear_gpio(input logic [7:0] a, input logic [7:0] bits);
        write_reg(a, bits);
        write_reg(8'h14, 8'h01);
    endtask
endmodule // gism_host_model

// ==== verification/gism_irq_ctrl_tb.sv ====
// self-checking bench for the interrupt status and mask block
// assumes the host model drives every register access
`timescale 1ns/1ns
`include "gism_params.svh"
module gism_irq_ctrl_tb;
    typedef struct packed {
        logic [8:0] src; logic [23:0] pin; logic [7:0] addr; logic [7:0] exp;
    } gism_row_type;
    logic                       sys_clk = 1'b0;
    logic                       reset   = 1'b1;
    gism_pkg::gism_reg_req_type reg_req;
    gism_pkg::gism_events_type  events  = '0;
    logic [7:0]                 rdata_q;
    logic                       rvalid_q, irq_q, irq_oe_q;
    int                         fails = 0;
    int                         check_count = 0;
    gism_row_type rows [7] = '{'{9'h001, 24'h0, 8'h15, 8'h01}, '{9'h006, 24'h0, 8'h15, 8'h06},
        '{9'h018, 24'h0, 8'h15, 8'h18}, '{9'h0E0, 24'h0, 8'h15, 8'hE0},
        '{9'h000, 24'h800000, 8'h19, 8'h80}, '{9'h000, 24'h00A500, 8'h1A, 8'hA5},
        '{9'h000, 24'h000001, 8'h1B, 8'h01}};
    always #10 sys_clk = ~sys_clk;
    gism_host_model gism_host_model_i (.sys_clk(sys_clk), .reg_req(reg_req),
        .rdata_q(rdata_q), .rvalid_q(rvalid_q));
    gism_irq_ctrl gism_irq_ctrl_i (.sys_clk(sys_clk), .reset(reset), .reg_req(reg_req),
        .events(events), .rdata_q(rdata_q), .rvalid_q(rvalid_q), .irq_q(irq_q),
        .irq_oe_q(irq_oe_q));
    task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic check_bit(input logic g, input logic e);
        check_byte({7'h00, g}, {7'h00, e});
    endtask
    task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       v;
        gism_host_model_i.read_reg(a, d, v);
        check_bit(v, 1'b1);
        check_byte(d, e);
    endtask
    task automatic fire(input logic [8:0] s, input logic [23:0] p);
        @(negedge sys_clk) events = '{wakeup: s[0], keypad: s[2:1], rotator: s[3],
            rotator_overflow: s[4], pwm: s[7:5], gpio_pin: p};
        @(negedge sys_clk) events = '0;
    endtask
    task automatic wait_irq(input logic e);
        repeat (3) @(negedge sys_clk);
        check_bit(irq_q, e);
        check_bit(irq_oe_q, e);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge sys_clk);
        reset = 1'b0;
        for (int a = 16; a < 28; a++) expect_reg(8'(a), 8'h00);
        expect_reg(8'h00, 8'h00);
        foreach (rows[i]) begin
            fire(rows[i].src, rows[i].pin);
            expect_reg(rows[i].addr, rows[i].exp);
            gism_host_model_i.write_reg(rows[i].addr, rows[i].exp);
            expect_reg(rows[i].addr, 8'h00);
        end
        for (int i = 0; i < 3; i++) gism_host_model_i.write_reg(8'(22 + i), 8'h81 >> i);
        for (int i = 0; i < 3; i++) expect_reg(8'(22 + i), 8'h81 >> i);
        gism_host_model_i.write_reg(`GISM_ADDR_ICR_MSB, 8'hFF);
        expect_reg(`GISM_ADDR_ICR_MSB, 8'h00);
        gism_host_model_i.write_reg(`GISM_ADDR_PEN_LOW, 8'h01);
        gism_host_model_i.write_reg(8'h12, 8'h01);
        gism_host_model_i.write_reg(`GISM_ADDR_ICR_LSB, 8'h01);
        fire(9'h000, 24'h000002);
        wait_irq(1'b0);
        expect_reg(8'h14, 8'h00);
        fire(9'h000, 24'h000001);
        wait_irq(1'b1);
        gism_host_model_i.write_reg(`GISM_ADDR_ICR_LSB, 8'h00);
        wait_irq(1'b0);
        expect_reg(8'h12, 8'h01);
        gism_host_model_i.write_reg(`GISM_ADDR_ICR_LSB, 8'h01);
        wait_irq(1'b1);
        expect_reg(8'h14, 8'h01);
        gism_host_model_i.clear_gpio(`GISM_ADDR_PST_LOW, 8'h03);
        wait_irq(1'b0);
        gism_host_model_i.write_reg(`GISM_ADDR_ICR_LSB, 8'h03);
        fire(9'h000, 24'h000001);
        wait_irq(1'b1);
        repeat (11) @(negedge sys_clk);
        check_bit(irq_q, 1'b1);
        @(negedge sys_clk);
        check_bit(irq_q, 1'b0);
        gism_host_model_i.write_reg(`GISM_ADDR_ICR_LSB, 8'h05);
        repeat (2) @(negedge sys_clk);
        check_bit(irq_q, 1'b1);
        check_bit(irq_oe_q, 1'b0);
        reset = 1'b1;
        repeat (2) @(negedge sys_clk);
        reset = 1'b0;
        check_bit(irq_q, 1'b0);
        expect_reg(`GISM_ADDR_PST_LOW, 8'h00);
        expect_reg(`GISM_ADDR_ICR_LSB, 8'h00);
        summarize();
    end
endmodule // gism_irq_ctrl_tb
